// ==== verilog/smsr_supply_monitor.sv ====
// supply monitor control and status register block with apb access
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module smsr_supply_monitor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog comparator outputs, high while below threshold
  input  wire logic        supplyBelow,
  input  wire logic        senseBelow,
  // option configuration and reset cause from the reset manager
  input  wire logic        undervoltageEnabled,
  input  wire logic        lowVoltageResetCause,
  input  wire logic        watchdogResetCause,
  // core state
  input  wire logic        coreIrqMask,
  input  wire logic        waitMode,
  input  wire logic        haltMode,
  input  wire logic        serviceEntry,
  // requests
  output logic             voltageWarnIrq,
  output logic             wakeFromWait,
  output logic             sysIrq
);

  // register state
  logic                          detectSourceSelect_reg;
  logic                          voltageWarnIrqEnable_reg;
  logic                          voltageWarnFlag_reg;
  logic                          lowVoltageResetFlag_reg;
  logic                          watchdogResetFlag_reg;
  logic                          warnPending_reg;
  logic [smsr_pkg::EVENT_COUNT-1:0] irqStatus_reg;
  logic [smsr_pkg::EVENT_COUNT-1:0] irqEnable_reg;

  // next values
  logic                          voltageWarnFlag_next;
  logic                          warnPending_next;
  logic [smsr_pkg::EVENT_COUNT-1:0] irqStatus_next;
  logic [smsr_pkg::EVENT_COUNT-1:0] eventPulse;

  // synchronised comparator levels
  logic [1:0] compStable;
  wire        supplyStable = compStable[0];
  wire        senseStable  = compStable[1];

  smsr_pin_sync #(
    .WIDTH (2)
  ) u_comp_sync (
    .clk       (clk),
    .reset     (reset),
    .pinIn     ({senseBelow, supplyBelow}),
    .pinStable (compStable)
  );

  // apb address decode
  wire apbSetup     = psel & ~penable;
  wire apbAccess    = psel & penable;
  wire hitInteg     = (paddr == smsr_pkg::OFF_INTEGRITY);
  wire hitStatus    = (paddr == smsr_pkg::OFF_IRQ_STATUS);
  wire hitClear     = (paddr == smsr_pkg::OFF_IRQ_CLEAR);
  wire hitEnable    = (paddr == smsr_pkg::OFF_IRQ_ENABLE);
  wire hitAny       = hitInteg | hitStatus | hitClear | hitEnable;
  wire apbWrite     = apbAccess & pwrite & hitAny;
  // the core is stopped in halt, so integrity register writes are blocked there too
  wire wrInteg      = apbWrite & hitInteg & ~haltMode;
  wire wrClear      = apbWrite & hitClear;
  wire wrEnable     = apbWrite & hitEnable;

  // zero wait state slave; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~hitAny;

  // comparator source selection, idle without the undervoltage unit
  wire selectedBelow = detectSourceSelect_reg ? senseStable
                                              : supplyStable;
  wire detectActive  = undervoltageEnabled;
  wire flagSampled   = detectActive & selectedBelow;

  // flag follows the comparator, frozen in halt
  assign voltageWarnFlag_next = haltMode ? voltageWarnFlag_reg
                                         : flagSampled;
  wire flagChange = voltageWarnFlag_next ^ voltageWarnFlag_reg;

  // pending request: set on any flag change while enabled; the set
  // wins over a service entry in the same cycle so no change is lost
  wire pendingSet = flagChange & voltageWarnIrqEnable_reg;
  assign warnPending_next =
    haltMode ? warnPending_reg :
    pendingSet ? 1'b1 :
    (serviceEntry | ~voltageWarnIrqEnable_reg) ? 1'b0 :
    warnPending_reg;

  // request to the core, gated by enable and core mask
  assign voltageWarnIrq = warnPending_reg & voltageWarnIrqEnable_reg &
                          ~coreIrqMask;
  // wake only from wait; the wake output is gated off in halt, so even a request already pending cannot wake it
  assign wakeFromWait = warnPending_reg & voltageWarnIrqEnable_reg &
                        waitMode & ~haltMode;

  // sticky event bits of the generic interrupt group
  always_comb begin
    eventPulse = '0;
    eventPulse[smsr_pkg::EV_FLAG_TOGGLE] = flagChange;
    eventPulse[smsr_pkg::EV_FLAG_SET]    = flagChange &
                                           voltageWarnFlag_next;
    eventPulse[smsr_pkg::EV_FLAG_CLEAR]  = flagChange &
                                           ~voltageWarnFlag_next;
  end

  // a clear written in the same cycle as an event loses to the event
  assign irqStatus_next = (irqStatus_reg &
                           ~(wrClear ? pwdata[smsr_pkg::EVENT_COUNT-1:0]
                                     : {smsr_pkg::EVENT_COUNT{1'b0}})) |
                          eventPulse;
  assign sysIrq = |(irqStatus_reg & irqEnable_reg);

  // software control bits
  always_ff @(posedge clk) begin
    if (reset) begin
      detectSourceSelect_reg   <= smsr_pkg::RST_DETECT_SOURCE_SELECT;
      voltageWarnIrqEnable_reg <= smsr_pkg::RST_VOLTAGE_WARN_IRQ_EN;
    end else if (wrInteg) begin
      detectSourceSelect_reg   <=
        pwdata[smsr_pkg::BIT_DETECT_SOURCE_SELECT];
      voltageWarnIrqEnable_reg <=
        pwdata[smsr_pkg::BIT_VOLTAGE_WARN_IRQ_EN];
    end
  end

  // flag and pending request; write data never reach the flag
  always_ff @(posedge clk) begin
    if (reset) begin
      voltageWarnFlag_reg <= 1'b0;
      warnPending_reg     <= 1'b0;
    end else begin
      voltageWarnFlag_reg <= voltageWarnFlag_next;
      warnPending_reg     <= warnPending_next;
    end
  end

  // reset cause flags: the low voltage flag lives through the block reset on purpose while the undervoltage unit is on,
  // the cause inputs are sampled while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      // pin or watchdog keep the undervoltage record; flag held at
      // zero when the unit is off instead of being left undefined
      lowVoltageResetFlag_reg <= undervoltageEnabled &
        (lowVoltageResetFlag_reg | lowVoltageResetCause);
      // undervoltage clears it, watchdog sets it, pin clears it
      watchdogResetFlag_reg   <= ~lowVoltageResetCause &
                                 watchdogResetCause;
    end else if (wrInteg) begin
      // writing zero clears; writing one leaves the flag as it is
      if (!pwdata[smsr_pkg::BIT_LOW_VOLTAGE_RESET_FLG]) begin
        lowVoltageResetFlag_reg <= 1'b0;
      end
      if (!pwdata[smsr_pkg::BIT_WATCHDOG_RESET_FLAG]) begin
        watchdogResetFlag_reg <= 1'b0;
      end
    end
  end

  // generic interrupt status and enable
  always_ff @(posedge clk) begin
    if (reset) begin
      irqStatus_reg <= '0;
      irqEnable_reg <= smsr_pkg::RST_IRQ_ENABLE;
    end else begin
      irqStatus_reg <= irqStatus_next;
      if (wrEnable) begin
        irqEnable_reg <= pwdata[smsr_pkg::EVENT_COUNT-1:0];
      end
    end
  end

  // integrity register image; bits 3 to 1 read zero
  logic [7:0] integImage;
  always_comb begin
    integImage = 8'h00;
    integImage[smsr_pkg::BIT_DETECT_SOURCE_SELECT]  = detectSourceSelect_reg;
    integImage[smsr_pkg::BIT_VOLTAGE_WARN_IRQ_EN]   = voltageWarnIrqEnable_reg;
    integImage[smsr_pkg::BIT_VOLTAGE_WARN_FLAG]     = voltageWarnFlag_reg;
    integImage[smsr_pkg::BIT_LOW_VOLTAGE_RESET_FLG] = lowVoltageResetFlag_reg;
    integImage[smsr_pkg::BIT_WATCHDOG_RESET_FLAG]   = watchdogResetFlag_reg;
  end

  // read mux; the clear register is write only and reads zero
  wire [31:0] readValue =
    hitInteg  ? {24'h000000, integImage} :
    hitStatus ? {29'h00000000, irqStatus_reg} :
    hitEnable ? {29'h00000000, irqEnable_reg} :
    32'h00000000;

  // read data captured in the setup cycle, valid through the access
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (apbSetup) begin
      prdata <= readValue;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_IRQ_GATED: assert property (
    voltageWarnIrq |-> voltageWarnIrqEnable_reg && !coreIrqMask)
    else $error("warning request without enable or with core mask set");

  AST_WAIT_ONLY: assert property (
    wakeFromWait |-> waitMode && !haltMode && warnPending_reg)
    else $error("wake raised outside wait mode");

  AST_SOURCE_ROUTE: assert property (
    (undervoltageEnabled && detectSourceSelect_reg && !haltMode)
    |=> voltageWarnFlag_reg == $past(senseStable))
    else $error("flag does not follow the sense pin when selected");

  AST_INACTIVE_OFF: assert property (
    (!undervoltageEnabled && !haltMode) |=> !voltageWarnFlag_reg)
    else $error("flag active while undervoltage unit disabled");

  AST_TOGGLE_PENDS: assert property (
    (!haltMode && voltageWarnIrqEnable_reg && flagChange)
    |=> warnPending_reg ##0 voltageWarnFlag_reg != $past(voltageWarnFlag_reg))
    else $error("flag change did not raise a pending request");

  AST_DISABLED_QUIET: assert property (
    (!voltageWarnIrqEnable_reg && !haltMode) |=> !warnPending_reg)
    else $error("request pending while enable bit is clear");

  AST_SERVICE_CLEAR: assert property (
    (serviceEntry && !pendingSet && !haltMode) |=> !warnPending_reg)
    else $error("pending request survived service entry");

  AST_HALT_FROZEN: assert property (
    haltMode |=> $stable(integImage) && $stable(warnPending_reg))
    else $error("integrity register changed in halt");

  AST_FLAG_WRITE_IGNORED: assert property (
    (wrInteg && flagSampled == voltageWarnFlag_reg)
    |=> voltageWarnFlag_reg == $past(voltageWarnFlag_reg))
    else $error("write changed the comparator flag");

  AST_ZERO_WRITE_CLEARS: assert property (
    (wrInteg && !pwdata[smsr_pkg::BIT_LOW_VOLTAGE_RESET_FLG])
    |=> !lowVoltageResetFlag_reg)
    else $error("writing zero left the low voltage reset flag set");

  AST_UV_RESET_CAUSE: assert property (
    @(posedge clk) disable iff (1'b0)
    (reset && lowVoltageResetCause && undervoltageEnabled)
    |=> lowVoltageResetFlag_reg && !watchdogResetFlag_reg)
    else $error("undervoltage reset not recorded");

  AST_PIN_RESET_KEEPS: assert property (
    @(posedge clk) disable iff (1'b0)
    (reset && !lowVoltageResetCause && !watchdogResetCause &&
     undervoltageEnabled)
    |=> $stable(lowVoltageResetFlag_reg) && !watchdogResetFlag_reg)
    else $error("pin reset disturbed the reset flags");

  COV_TOGGLE_REQUEST: cover property (
    pendingSet ##1 voltageWarnIrq);
  COV_SERVICE_ENTRY: cover property (
    warnPending_reg && serviceEntry ##1 !warnPending_reg);
  COV_WATCHDOG_RESET: cover property (
    @(posedge clk) disable iff (1'b0)
    reset && watchdogResetCause ##1 watchdogResetFlag_reg);
  COV_EVENT_IRQ: cover property (sysIrq);

endmodule

`default_nettype wire

// ==== verilog/smsr_pkg.sv ====
// shared constants of the supply monitor status block
package smsr_pkg;

  // apb register byte offsets
  localparam logic [11:0] OFF_INTEGRITY  = 12'h000;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_CLEAR  = 12'h008;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h00c;

  // fields of system_integrity_ctrl_status
  localparam int BIT_DETECT_SOURCE_SELECT  = 7;
  localparam int BIT_VOLTAGE_WARN_IRQ_EN   = 6;
  localparam int BIT_VOLTAGE_WARN_FLAG     = 5;
  localparam int BIT_LOW_VOLTAGE_RESET_FLG = 4;
  localparam int BIT_WATCHDOG_RESET_FLAG   = 0;

  // reset values of the software control bits
  localparam logic RST_DETECT_SOURCE_SELECT = 1'b0;
  localparam logic RST_VOLTAGE_WARN_IRQ_EN  = 1'b0;

  // event bits of status, clear and enable registers
  localparam int EVENT_COUNT    = 3;
  localparam int EV_FLAG_TOGGLE = 0;
  localparam int EV_FLAG_SET    = 1;
  localparam int EV_FLAG_CLEAR  = 2;
  localparam logic [EVENT_COUNT-1:0] RST_IRQ_ENABLE = 3'h0;

  // depth of the pin synchroniser
  localparam int SYNC_STAGES = 3;

endpackage

// ==== verilog/smsr_pin_sync.sv ====
// three-stage synchroniser with agreement filter for comparator pins
`timescale 1ns/10ps
`default_nettype none

module smsr_pin_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // asynchronous levels
  input  wire logic [WIDTH-1:0] pinIn,
  // filtered levels in the clock domain
  output logic      [WIDTH-1:0] pinStable
);

  initial begin
    if (WIDTH < 1) begin
      $error("smsr_pin_sync: WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] stable_next;

  // a bit moves only once stages two and three agree; stage one is
  // read by stage two alone so metastability never reaches a gate
  assign stable_next = (stage2_reg & stage3_reg) |
                       (pinStable & (stage2_reg | stage3_reg));

  // shift chain and filtered output
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      pinStable  <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      pinStable  <= stable_next;
    end
  end

endmodule

`default_nettype wire

// ==== sim/tb_smsr_supply_monitor.sv ====
// self-checking testbench of the supply monitor status block
`timescale 1ns/10ps
`default_nettype none

module tb_smsr_supply_monitor;
  logic        clk, reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic        supplyBelow, senseBelow, undervoltageEnabled;
  logic        lowVoltageResetCause, watchdogResetCause;
  logic        coreIrqMask, waitMode, haltMode, serviceEntry;
  logic        voltageWarnIrq, wakeFromWait, sysIrq;
  int          err_count, check_count, cycles;

  smsr_supply_monitor uut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supplyBelow(supplyBelow),
    .senseBelow(senseBelow), .undervoltageEnabled(undervoltageEnabled),
    .lowVoltageResetCause(lowVoltageResetCause),
    .watchdogResetCause(watchdogResetCause), .coreIrqMask(coreIrqMask),
    .waitMode(waitMode), .haltMode(haltMode), .serviceEntry(serviceEntry),
    .voltageWarnIrq(voltageWarnIrq), .wakeFromWait(wakeFromWait),
    .sysIrq(sysIrq)
  );

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                       input string msg);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask

  // comparator change needs five edges to reach the flag
  task automatic settle();
    repeat (7) @(posedge clk);
  endtask

  task automatic pulse_service();
    @(posedge clk) serviceEntry <= 1'b1;
    @(posedge clk) serviceEntry <= 1'b0;
    @(posedge clk);
  endtask

  // reset with a given cause, then flush the synchroniser
  task automatic do_reset(input logic lv, input logic wd);
    @(posedge clk);
    reset <= 1'b1;
    lowVoltageResetCause <= lv;
    watchdogResetCause   <= wd;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    lowVoltageResetCause <= 1'b0;
    watchdogResetCause   <= 1'b0;
    settle();
  endtask

  // control bits, read-only flag and reserved positions
  task automatic t_bits();
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h10, "power-on flags");
    apb(1'b1, smsr_pkg::OFF_INTEGRITY, 32'hf1);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'hd0, "write ones");
    apb(1'b1, smsr_pkg::OFF_INTEGRITY, 32'hc0);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'hc0, "clear lv flag");
  endtask

  // warning on both edges of the selected comparator
  task automatic t_warn();
    supplyBelow <= 1'b1;
    settle();
    chk_bit(voltageWarnIrq, 1'b0, "unselected source");
    senseBelow <= 1'b1;
    settle();
    chk_bit(voltageWarnIrq, 1'b1, "rising flag irq");
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'he0, "flag set");
    rdchk(smsr_pkg::OFF_IRQ_STATUS, 32'h3, "status set");
    pulse_service();
    chk_bit(voltageWarnIrq, 1'b0, "service clears");
    coreIrqMask <= 1'b1;
    waitMode    <= 1'b1;
    senseBelow  <= 1'b0;
    settle();
    chk_bit(voltageWarnIrq, 1'b0, "masked by core");
    chk_bit(wakeFromWait, 1'b1, "falling flag wakes");
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'hc0, "flag clear");
  endtask

  // halt freezes the register and blocks wake-up
  task automatic t_halt();
    @(posedge clk) haltMode <= 1'b1;
    @(posedge clk);
    chk_bit(wakeFromWait, 1'b0, "no halt exit");
    apb(1'b1, smsr_pkg::OFF_INTEGRITY, 32'h00);
    senseBelow <= 1'b1;
    settle();
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'hc0, "frozen in halt");
    haltMode <= 1'b0;
    settle();
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'he0, "after halt");
    waitMode    <= 1'b0;
    coreIrqMask <= 1'b0;
    pulse_service();
  endtask

  // sticky status, enable, clear and an unmapped address
  task automatic t_irq_regs();
    chk_bit(sysIrq, 1'b0, "irq disabled");
    apb(1'b1, smsr_pkg::OFF_IRQ_ENABLE, 32'h7);
    rdchk(smsr_pkg::OFF_IRQ_ENABLE, 32'h7, "enable readback");
    chk_bit(err, 1'b0, "mapped access no error");
    chk_bit(pready, 1'b1, "zero wait slave");
    chk_bit(sysIrq, 1'b1, "irq raised");
    apb(1'b1, smsr_pkg::OFF_IRQ_STATUS, 32'h0);
    rdchk(smsr_pkg::OFF_IRQ_STATUS, 32'h7, "status read only");
    apb(1'b1, smsr_pkg::OFF_IRQ_CLEAR, 32'h7);
    rdchk(smsr_pkg::OFF_IRQ_STATUS, 32'h0, "status cleared");
    chk_bit(sysIrq, 1'b0, "irq cleared");
    apb(1'b0, 12'h010, 32'h0);
    chk_bit(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
  endtask

  // enable bit low blocks the request
  task automatic t_ie_off();
    apb(1'b1, smsr_pkg::OFF_INTEGRITY, 32'h80);
    senseBelow <= 1'b0;
    settle();
    chk_bit(voltageWarnIrq, 1'b0, "enable low");
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h80, "flag follows");
  endtask

  // reset cause encoding across reset kinds
  task automatic t_resets();
    supplyBelow <= 1'b0;
    do_reset(1'b1, 1'b0);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h10, "lv reset");
    do_reset(1'b0, 1'b1);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h11, "wdg keeps lv");
    // zero on bit 0 clears it, a one on bit 4 leaves that flag alone
    apb(1'b1, smsr_pkg::OFF_INTEGRITY, 32'h10);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h10, "wdg write zero");
    do_reset(1'b1, 1'b1);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h10, "lv clears wdg");
    do_reset(1'b0, 1'b0);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h10, "pin keeps lv");
    apb(1'b1, smsr_pkg::OFF_INTEGRITY, 32'h00);
    rdchk(smsr_pkg::OFF_INTEGRITY, 32'h00, "pin reset");
  endtask

  // detection idle while the undervoltage unit is off
  task automatic t_uv_off();
    undervoltageEnabled <= 1'b0;
    supplyBelow <= 1'b1;
    settle();
    apb(1'b0, smsr_pkg::OFF_INTEGRITY, 32'h0);
    chk(rd & 32'h20, 32'h0, "detector inactive");
  endtask

  // main sequence
  initial begin
    err_count = 0;
    check_count = 0;
    cycles = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    supplyBelow = 1'b0;
    senseBelow = 1'b0;
    undervoltageEnabled = 1'b1;
    lowVoltageResetCause = 1'b1;
    watchdogResetCause = 1'b0;
    coreIrqMask = 1'b0;
    waitMode = 1'b0;
    haltMode = 1'b0;
    serviceEntry = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    lowVoltageResetCause <= 1'b0;
    settle();
    t_bits();
    t_warn();
    t_halt();
    t_irq_regs();
    t_ie_off();
    t_resets();
    t_uv_off();
    give_verdict();
  end
endmodule

`default_nettype wire
